// >>> design/pmctl_defs.vh
// Purpose: constants of the power-mode sequencer
// Assumes: 32-bit apb, word-aligned registers
// Notes:   times in ns, wake delay count derived from the clock period
`ifndef PMCTL_DEFS_VH
`define PMCTL_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PM_OFF_OSC    8'h00
`define PM_OFF_WDT    8'h04
`define PM_OFF_IRQ    8'h08
`define PM_OFF_DSH    8'h0C
`define PM_OFF_DSL    8'h10
`define PM_OFF_WAKE   8'h14
`define PM_OFF_GPR0   8'h18
`define PM_OFF_GPR1   8'h1C
`define PM_OFF_DIR    8'h20
`define PM_OFF_LAT    8'h24
`define PM_OFF_CFG    8'h28
`define PM_OFF_STAT   8'h2C
// ----------------------------------------
// field positions
// ----------------------------------------
`define PM_B_IDLE     7
`define PM_B_SECONDARY_CLOCK_ACTIVE_FLAG  6
`define PM_B_PRIACT   3
`define PM_B_SOSCEN   2
`define PM_B_REGULATOR_SLEEP_BIT   7
`define PM_B_DSFLAG   3
`define PM_B_GIE      7
`define PM_B_DEEP_SLEEP_ENABLE     7
`define PM_B_DEEP_BROWNOUT    1
`define PM_B_RELEASE  0
// ----------------------------------------
// reset values and clock selections
// ----------------------------------------
`define PM_RST_BYTE   8'h00
`define PM_RST_DIR    8'hFF
`define PM_CLK_PRI    2'h0
`define PM_CLK_SEC    2'h1
`define PM_CLK_INT    2'h2
`define PM_CLK_LF     2'h3
`define PM_PRI_XTAL   2'h0
`define PM_PRI_EC     2'h1
`define PM_PRI_EXTERNAL_CLOCK_PLL_MODE  2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define PM_CLK_NS     25
`define PM_CPU_WAKE_DELAY_NS    200
`define PM_CPU_WAKE_DELAY_CYC   ((`PM_CPU_WAKE_DELAY_NS + `PM_CLK_NS - 1) / `PM_CLK_NS)
`define PM_OST_CYC    1024
`define PM_DEEP_SLEEP_ENABLE_LIFE  2
`endif

// >>> design/pmctl_top.v
// Purpose: sequencer for idle, sleep and deep sleep modes
// Assumes: cpu events are one-cycle pulses synchronous to pclk
// Notes:   apb slave with zero wait states; pins held in deep sleep
`timescale 1ns/1ps
`include "pmctl_defs.vh"

module pmctl_top #(
  parameter NPIN     = 8,
  parameter CPU_WAKE_DELAY_CYC = `PM_CPU_WAKE_DELAY_CYC,
  parameter OST_CYC  = `PM_OST_CYC,
  parameter IDIV     = 4
)(
  input  wire            pclk,
  input  wire            presetn,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [7:0]      paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  input  wire            sleep_instr,
  input  wire            watchdog_clear_instr_instr,
  input  wire            irq_pending,
  input  wire            wdt_timeout,
  input  wire            master_clear_pin_rst,
  input  wire            clock_lost,
  input  wire            sosc_running,
  input  wire            wake_alarm,
  input  wire            wake_ext_irq_zero,
  input  wire            wake_ulp,
  input  wire            wake_deep_watchdog,
  input  wire            deep_brownout_loss,
  output reg             cpu_clk_en,
  output reg             periph_clk_en,
  output reg  [1:0]      sys_clk_sel,
  output reg             pri_osc_en,
  output reg             lf_osc_en,
  output reg             core_reg_en,
  output reg             wdt_clear,
  output reg             wdt_reset,
  output reg             irq_vector,
  output reg             por_pulse,
  output reg  [NPIN-1:0] pin_out,
  output reg  [NPIN-1:0] pin_oe
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] S_RUN  = 3'h0;
  localparam [2:0] S_SEC  = 3'h1;
  localparam [2:0] S_RCI  = 3'h2;
  localparam [2:0] S_PRI  = 3'h3;
  localparam [2:0] S_SLP  = 3'h4;
  localparam [2:0] S_WAKE = 3'h5;
  localparam [2:0] S_DSE  = 3'h6;
  localparam [2:0] S_DEEP = 3'h7;
  // wake counts, cut to the 16-bit counter on purpose
  localparam [31:0] WAKE_FULL = CPU_WAKE_DELAY_CYC + OST_CYC;
  localparam [31:0] WAKE_FAST = CPU_WAKE_DELAY_CYC;

  reg  [2:0]      state;
  reg  [2:0]      next_state;
  reg  [15:0]     wcnt;
  reg  [15:0]     next_wcnt;
  reg             idle_sel;
  reg  [1:0]      css;
  reg             sosc_en;
  reg             pri_act;
  reg             sosc_act;
  reg             regulator_sleep_bit;
  reg             ds_flag;
  reg             gie;
  reg             deep_sleep_enable;
  reg  [1:0]      deep_sleep_enable_age;
  reg             deep_brownout_flag;
  reg             release_bit;
  reg  [4:0]      wake_src;
  reg  [7:0]      gpr0;
  reg  [7:0]      gpr1;
  reg  [NPIN-1:0] dir;
  reg  [NPIN-1:0] lat;
  reg  [NPIN-1:0] held_oe;
  reg  [NPIN-1:0] held_out;
  reg  [1:0]      pri_mode;
  reg             wdt_en;
  reg             clock_fail_monitor_en;
  reg  [3:0]      idiv;
  reg             soft_por;
  wire            instr_tick;
  wire            wr;
  wire            rd_setup;
  wire [4:0]      wake_vec;
  wire            any_wake;
  wire            asleep;
  wire            ds_ok;

  // decode a mapped word offset
  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `PM_OFF_STAT);
    end
  endfunction

  // ----------------------------------------
  // instruction-cycle enable
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idiv <= 4'h0;
    else if (idiv == IDIV - 1)
      idiv <= 4'h0;
    else
      idiv <= idiv + 4'h1;
  end
  assign instr_tick = (idiv == IDIV - 1);

  // wake sources in log order: master_clear_pin, alarm, ext_irq_zero, ulp, deep_watchdog
  assign wake_vec = {wake_deep_watchdog, wake_ulp, wake_ext_irq_zero, wake_alarm, master_clear_pin_rst};
  assign any_wake = |wake_vec;
  assign asleep   = (state == S_SEC) || (state == S_RCI) ||
                    (state == S_PRI) || (state == S_SLP);
  // deep entry only with regulator sleep, no idle, no interrupts
  assign ds_ok    = deep_sleep_enable && regulator_sleep_bit && !idle_sel && !gie;
  assign wr       = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  // ----------------------------------------
  // mode sequencer
  // ----------------------------------------
  always @*
  begin
    next_state = state;
    next_wcnt  = wcnt;
    case (state)
      S_RUN:
        if (sleep_instr)
        begin
          if (ds_ok)
            next_state = S_DSE;
          else if (!idle_sel)
            next_state = S_SLP;
          else if (css == `PM_CLK_SEC)
            next_state = sosc_en ? S_SEC : S_RUN;
          else if (css == `PM_CLK_PRI && pri_act)
            next_state = S_PRI;
          else
            next_state = S_RCI;
        end
      S_SEC, S_RCI, S_PRI, S_SLP:
        if (master_clear_pin_rst || irq_pending || wdt_timeout)
        begin
          next_state = S_WAKE;
          // crystal start-up only after a full sleep, never on reset
          if (state == S_SLP && !master_clear_pin_rst && css == `PM_CLK_PRI &&
              pri_mode == `PM_PRI_XTAL)
            next_wcnt = WAKE_FULL[15:0];
          else
            next_wcnt = WAKE_FAST[15:0];
        end
      S_WAKE:
        if (wcnt <= 16'h1)
          next_state = S_RUN;
        else
          next_wcnt = wcnt - 16'h1;
      S_DSE:
      begin
        // an early source aborts entry, execution goes on after the delay
        next_state = (any_wake || irq_pending) ? S_WAKE : S_DEEP;
        next_wcnt  = WAKE_FAST[15:0];
      end
      S_DEEP:
        if (any_wake || deep_brownout_loss)
        begin
          next_state = S_WAKE;
          next_wcnt  = WAKE_FAST[15:0];
        end
      default:
        next_state = S_RUN;
    endcase
  end

  // ----------------------------------------
  // state, clocks and event pulses
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state         <= S_RUN;
      wcnt          <= 16'h0;
      cpu_clk_en    <= 1'b1;
      periph_clk_en <= 1'b1;
      sys_clk_sel   <= `PM_CLK_PRI;
      pri_osc_en    <= 1'b1;
      core_reg_en   <= 1'b1;
      lf_osc_en     <= 1'b0;
      wdt_clear     <= 1'b0;
      wdt_reset     <= 1'b0;
      irq_vector    <= 1'b0;
      por_pulse     <= 1'b0;
      soft_por      <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      wcnt       <= next_wcnt;
      // watchdog cleared on sleep, clear or lost clock with the monitor enabled
      wdt_clear  <= sleep_instr || watchdog_clear_instr_instr ||
                    (clock_lost && clock_fail_monitor_en);
      wdt_reset  <= wdt_timeout && !asleep &&
                    state != S_WAKE && state != S_DEEP;
      irq_vector <= asleep && irq_pending && !master_clear_pin_rst && gie;
      soft_por   <= state == S_DEEP && next_state == S_WAKE;
      por_pulse  <= state == S_DEEP && next_state == S_WAKE;
      // low-freq source kept for watchdog or monitor
      lf_osc_en  <= wdt_en || clock_fail_monitor_en ||
                    sys_clk_sel == `PM_CLK_LF;
      cpu_clk_en <= next_state == S_RUN;
      core_reg_en <= next_state != S_DEEP;
      case (next_state)
        S_SEC:
        begin
          sys_clk_sel   <= `PM_CLK_SEC;
          pri_osc_en    <= 1'b0;
          periph_clk_en <= sosc_running;
        end
        S_RCI:
        begin
          sys_clk_sel   <= `PM_CLK_INT;
          pri_osc_en    <= 1'b0;
          periph_clk_en <= 1'b1;
        end
        S_SLP, S_DSE, S_DEEP:
        begin
          periph_clk_en <= 1'b0;
          pri_osc_en    <= 1'b0;
        end
        S_WAKE:
        begin
          // source picked on the wake edge so it settles during the delay
          if (asleep && master_clear_pin_rst)
            sys_clk_sel <= `PM_CLK_LF;
          else if (state == S_DEEP || state == S_RCI)
            sys_clk_sel <= `PM_CLK_LF;
          else if (state == S_SLP || state == S_DSE)
            sys_clk_sel <= css;
          if (state == S_SLP || state == S_DSE)
            pri_osc_en <= (css == `PM_CLK_PRI);
        end
        S_RUN:
          periph_clk_en <= 1'b1;
        default:
          periph_clk_en <= periph_clk_en;
      endcase
    end
  end

  // ----------------------------------------
  // software registers, soft por aware
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_sel <= 1'b0;
      css      <= 2'h0;
      sosc_en  <= 1'b0;
      regulator_sleep_bit   <= 1'b0;
      gie      <= 1'b0;
      deep_sleep_enable     <= 1'b0;
      deep_sleep_enable_age <= 2'h0;
      dir      <= {NPIN{1'b1}};
      lat      <= {NPIN{1'b0}};
      pri_mode <= `PM_PRI_XTAL;
      wdt_en   <= 1'b0;
      clock_fail_monitor_en  <= 1'b0;
      pri_act  <= 1'b1;
      sosc_act <= 1'b0;
    end
    else if (soft_por)
    begin
      // deep exit resets all but retained state, pri_mode, wdt_en and clock_fail_monitor_en
      idle_sel <= 1'b0;
      css      <= 2'h0;
      sosc_en  <= 1'b0;
      regulator_sleep_bit   <= 1'b0;
      gie      <= 1'b0;
      deep_sleep_enable     <= 1'b0;
      deep_sleep_enable_age <= 2'h0;
      dir      <= {NPIN{1'b1}};
      lat      <= {NPIN{1'b0}};
      pri_act  <= 1'b1;
      sosc_act <= 1'b0;
    end
    else
    begin
      // status tracks the chosen source
      if (next_state == S_SEC)
      begin
        pri_act  <= 1'b0;
        sosc_act <= 1'b1;
      end
      else if (next_state == S_RCI)
        pri_act <= 1'b0;
      if (wr && paddr == `PM_OFF_OSC)
      begin
        idle_sel <= pwdata[`PM_B_IDLE];
        css      <= pwdata[1:0];
        sosc_en  <= pwdata[`PM_B_SOSCEN];
      end
      if (wr && paddr == `PM_OFF_WDT)
        regulator_sleep_bit <= pwdata[`PM_B_REGULATOR_SLEEP_BIT];
      if (wr && paddr == `PM_OFF_IRQ)
        gie <= pwdata[`PM_B_GIE];
      if (wr && paddr == `PM_OFF_DIR)
        dir <= pwdata[NPIN-1:0];
      if (wr && paddr == `PM_OFF_LAT)
        lat <= pwdata[NPIN-1:0];
      if (wr && paddr == `PM_OFF_CFG)
      begin
        pri_mode <= pwdata[1:0];
        wdt_en   <= pwdata[4];
        clock_fail_monitor_en  <= pwdata[5];
      end
      // enable lives two instruction cycles only
      if (wr && paddr == `PM_OFF_DSH)
      begin
        deep_sleep_enable     <= pwdata[`PM_B_DEEP_SLEEP_ENABLE];
        deep_sleep_enable_age <= 2'h0;
      end
      else if (deep_sleep_enable && instr_tick)
      begin
        if (deep_sleep_enable_age == `PM_DEEP_SLEEP_ENABLE_LIFE - 1)
          deep_sleep_enable <= 1'b0;
        deep_sleep_enable_age <= deep_sleep_enable_age + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // retained deep-sleep state
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gpr0        <= `PM_RST_BYTE;
      gpr1        <= `PM_RST_BYTE;
      wake_src    <= 5'h0;
      ds_flag     <= 1'b0;
      deep_brownout_flag  <= 1'b0;
      release_bit <= 1'b0;
      held_oe     <= {NPIN{1'b0}};
      held_out    <= {NPIN{1'b0}};
    end
    else
    begin
      if (state == S_DEEP && deep_brownout_loss)
      begin
        gpr0 <= `PM_RST_BYTE;
        gpr1 <= `PM_RST_BYTE;
      end
      else if (wr && paddr == `PM_OFF_GPR0)
        gpr0 <= pwdata[7:0];
      else if (wr && paddr == `PM_OFF_GPR1)
        gpr1 <= pwdata[7:0];
      // log cleared on entry, first source only
      if (state == S_DSE)
        wake_src <= 5'h0;
      else if (state == S_DEEP && wake_src == 5'h0 && any_wake)
        wake_src <= wake_vec & (~wake_vec + 5'h1);
      // hardware sets, software clears; set wins
      if (soft_por && !deep_brownout_loss)
        ds_flag <= 1'b1;
      else if (wr && paddr == `PM_OFF_WDT && !pwdata[`PM_B_DSFLAG])
        ds_flag <= 1'b0;
      if (state == S_DSE)
        deep_brownout_flag <= 1'b0;
      else if (wr && paddr == `PM_OFF_DSL)
        deep_brownout_flag <= pwdata[`PM_B_DEEP_BROWNOUT];
      // capture pins at entry, hold until released
      if (state == S_DSE && next_state == S_DEEP)
      begin
        release_bit <= 1'b1;
        held_oe     <= ~dir;
        held_out    <= lat;
      end
      else if (state == S_DEEP && (master_clear_pin_rst || deep_brownout_loss))
        release_bit <= 1'b0;
      else if (wr && paddr == `PM_OFF_DSL && !pwdata[`PM_B_RELEASE])
        release_bit <= 1'b0;
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1)
    begin : g_pin
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pin_out[gi] <= 1'b0;
          pin_oe[gi]  <= 1'b0;
        end
        else
        begin
          // held copy outranks reset direction and latch
          pin_out[gi] <= release_bit ? held_out[gi] : lat[gi];
          pin_oe[gi]  <= release_bit ? held_oe[gi] : ~dir[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // apb read path, zero wait states
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= 1'b1;
      if (rd_setup)
      begin
        pslverr <= !mapped(paddr);
        case (paddr)
          `PM_OFF_OSC:
            prdata <= {24'h0, idle_sel, sosc_act, 2'h0, pri_act,
                       sosc_en, css};
          `PM_OFF_WDT:
            prdata <= {24'h0, regulator_sleep_bit, 3'h0, ds_flag, 3'h0};
          `PM_OFF_IRQ:  prdata <= {24'h0, gie, 7'h0};
          `PM_OFF_DSH:  prdata <= {24'h0, deep_sleep_enable, 7'h0};
          `PM_OFF_DSL:
            prdata <= {29'h0, 1'b0, deep_brownout_flag, release_bit};
          `PM_OFF_WAKE: prdata <= {27'h0, wake_src};
          `PM_OFF_GPR0: prdata <= {24'h0, gpr0};
          `PM_OFF_GPR1: prdata <= {24'h0, gpr1};
          `PM_OFF_DIR:  prdata <= {{(32-NPIN){1'b0}}, dir};
          `PM_OFF_LAT:  prdata <= {{(32-NPIN){1'b0}}, lat};
          `PM_OFF_CFG:
            prdata <= {26'h0, clock_fail_monitor_en, wdt_en, 2'h0, pri_mode};
          `PM_OFF_STAT: prdata <= {29'h0, state};
          default:      prdata <= 32'h0;
        endcase
      end
    end
  end

endmodule

// >>> verif/pmctl_assertions.sv
// Purpose: port-level checks on the power-mode sequencer
// Assumes: one pclk domain, presetn async and active low
// Notes:   bound into every pmctl_top instance at the foot
`timescale 1ns/1ps
module pmctl_assertions #(
  parameter NPIN     = 8,
  parameter CPU_WAKE_DELAY_CYC = 8
)(
  input logic            pclk,
  input logic            presetn,
  input logic            sleep_instr,
  input logic            watchdog_clear_instr_instr,
  input logic            wdt_timeout,
  input logic            master_clear_pin_rst,
  input logic            clock_lost,
  input logic            deep_brownout_loss,
  input logic            cpu_clk_en,
  input logic [1:0]      sys_clk_sel,
  input logic            pri_osc_en,
  input logic            core_reg_en,
  input logic            wdt_clear,
  input logic            wdt_reset,
  input logic            irq_vector,
  input logic            por_pulse,
  input logic [NPIN-1:0] pin_out,
  input logic [NPIN-1:0] pin_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // cpu clock falls only after a sleep and wakes no sooner than the delay
  a_stop_by_sleep: assert property ($fell(cpu_clk_en) |-> $past(sleep_instr))
    else $error("cpu clock stopped without sleep");
  a_wake_delay: assert property ($rose(cpu_clk_en) |-> !$past(cpu_clk_en, CPU_WAKE_DELAY_CYC))
    else $error("cpu resumed before wake delay");
  // primary oscillator is off whenever the secondary or internal source clocks the part
  a_sec_pri_off: assert property (sys_clk_sel == 2'h1 |-> !pri_osc_en)
    else $error("primary on while on secondary");
  a_int_pri_off: assert property (sys_clk_sel == 2'h2 |-> !pri_osc_en)
    else $error("primary on while on internal block");
  // watchdog: reset while running, none while asleep, clears with a cause
  a_run_wdt_reset: assert property (
    wdt_timeout && cpu_clk_en && core_reg_en && !sleep_instr |=> wdt_reset)
    else $error("no watchdog reset in run");
  a_asleep_no_reset: assert property (wdt_reset |-> $past(cpu_clk_en))
    else $error("watchdog reset while asleep");
  a_clear_follows: assert property ((sleep_instr || watchdog_clear_instr_instr) && cpu_clk_en |=> wdt_clear)
    else $error("watchdog not cleared");
  a_clear_cause: assert property (wdt_clear |->
    $past(sleep_instr) || $past(watchdog_clear_instr_instr) || $past(clock_lost))
    else $error("watchdog cleared without cause");
  // deep sleep: entry timing, held pins, reset on exit
  a_deep_entry: assert property ($fell(core_reg_en) |->
    $past(sleep_instr, 2) || $past(sleep_instr, 3))
    else $error("regulator off without sleep");
  a_deep_pins_hold: assert property (
    !core_reg_en && !$past(core_reg_en) && !$past(master_clear_pin_rst) && !$past(deep_brownout_loss)
    |-> $stable(pin_oe) && $stable(pin_out))
    else $error("pins moved in deep sleep");
  a_por_from_deep: assert property (por_pulse |-> !$past(core_reg_en))
    else $error("power-on pulse outside deep exit");
  a_vector_on_wake: assert property (irq_vector |-> !cpu_clk_en)
    else $error("vector outside a wake");

  // main scenarios reached
  c_deep: cover property ($fell(core_reg_en));
  c_vector: cover property (irq_vector);
  c_por: cover property (por_pulse);
  c_wdt_reset: cover property (wdt_reset);
endmodule

bind pmctl_top pmctl_assertions #(.NPIN(NPIN), .CPU_WAKE_DELAY_CYC(CPU_WAKE_DELAY_CYC)) chk (
  .pclk, .presetn, .sleep_instr, .watchdog_clear_instr_instr, .wdt_timeout, .master_clear_pin_rst, .clock_lost,
  .deep_brownout_loss, .cpu_clk_en, .sys_clk_sel, .pri_osc_en, .core_reg_en, .wdt_clear,
  .wdt_reset, .irq_vector, .por_pulse, .pin_out, .pin_oe);

// >>> verif/pmctl_cpu_model.sv
// Purpose: stand-in for cpu core, wake sources and oscillator status
// Assumes: lines change only just after a rising pclk edge
// Notes:   levels via on and off, one-cycle events via pulse
`timescale 1ns/1ps
module pmctl_cpu_model (
  input  wire pclk,
  output wire sleep_instr,
  output wire watchdog_clear_instr_instr,
  output wire irq_pending,
  output wire wdt_timeout,
  output wire master_clear_pin_rst,
  output wire clock_lost,
  output wire sosc_running,
  output wire wake_alarm,
  output wire wake_ext_irq_zero,
  output wire wake_ulp,
  output wire wake_deep_watchdog,
  output wire deep_brownout_loss
);
  // secondary oscillator already running, all events quiet
  logic [11:0] ev = 12'h040;

  assign {deep_brownout_loss, wake_deep_watchdog, wake_ulp, wake_ext_irq_zero, wake_alarm, sosc_running,
          clock_lost, master_clear_pin_rst, wdt_timeout, irq_pending, watchdog_clear_instr_instr, sleep_instr} = ev;

  // non-blocking after the edge so the design never sees a half-changed set
  task on(input logic [11:0] v);
    @(posedge pclk);
    ev <= ev | v;
  endtask

  task off(input logic [11:0] v);
    @(posedge pclk);
    ev <= ev & ~v;
  endtask

  task pulse(input logic [11:0] v);
    on(v);
    off(v);
  endtask
endmodule

// >>> verif/tb.sv
// Purpose: self-checking bench for the power-mode sequencer
// Assumes: apb slave with zero wait states, short start-up timer
// Notes:   expected counts derived from TC and OC set below
`timescale 1ns/1ps
`include "pmctl_defs.vh"
module tb;
  localparam int TC = 8;
  localparam int OC = 4;
  localparam logic [11:0] SLP = 12'h001, CLR = 12'h002, IRQ = 12'h004, WDT = 12'h008;
  localparam logic [11:0] MCL = 12'h010, LOST = 12'h020, ALM = 12'h080, EXT_IRQ_ZERO = 12'h100;

  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, serr, sleep_instr, watchdog_clear_instr_instr, irq_pending, wdt_timeout;
  logic        master_clear_pin_rst, clock_lost, sosc_running, wake_alarm, wake_ext_irq_zero, wake_ulp;
  logic        wake_deep_watchdog, deep_brownout_loss, cpu_clk_en, periph_clk_en, pri_osc_en, lf_osc_en;
  logic        core_reg_en, wdt_clear, wdt_reset, irq_vector, por_pulse;
  logic [1:0]  sys_clk_sel;
  logic [7:0]  pin_out, pin_oe;
  int          fail_count = 0, samples_checked = 0, por_seen = 0;

  pmctl_top #(.CPU_WAKE_DELAY_CYC(TC), .OST_CYC(OC)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sleep_instr, .watchdog_clear_instr_instr, .irq_pending, .wdt_timeout, .master_clear_pin_rst, .clock_lost,
    .sosc_running, .wake_alarm, .wake_ext_irq_zero, .wake_ulp, .wake_deep_watchdog, .deep_brownout_loss,
    .cpu_clk_en, .periph_clk_en, .sys_clk_sel, .pri_osc_en, .lf_osc_en, .core_reg_en,
    .wdt_clear, .wdt_reset, .irq_vector, .por_pulse, .pin_out, .pin_oe);

  pmctl_cpu_model cpu (
    .pclk, .sleep_instr, .watchdog_clear_instr_instr, .irq_pending, .wdt_timeout, .master_clear_pin_rst, .clock_lost,
    .sosc_running, .wake_alarm, .wake_ext_irq_zero, .wake_ulp, .wake_deep_watchdog, .deep_brownout_loss);

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  // one-cycle power-on pulses, sampled where settled
  always @(negedge pclk)
    if (por_pulse === 1'b1)
      por_seen++;

  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // request held until the rising edge that samples pready high; data taken there
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  // counts cycles from the wake event to cpu clock, level irq or pulsed source
  task wake(input logic [11:0] src, input int exp_n, input logic exp_v);
    int   n;
    logic v;
    n = 0;
    v = 1'b0;
    cpu.on(src);
    if (src != IRQ)
      cpu.off(src);
    while (cpu_clk_en !== 1'b1 && n < 3000)
    begin
      @(negedge pclk);
      n++;
      v = v | irq_vector;
    end
    chk(n, exp_n);
    chk(v, exp_v);
    cpu.off(src);
  endtask

  // enable then sleep, sampled on the third falling edge after the sleep pulse
  task deep;
    wr(`PM_OFF_DSH, 32'h80);
    cpu.pulse(SLP);
    repeat (3) @(negedge pclk);
    chk(core_reg_en, 0);
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_sim();
  end

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`PM_OFF_DIR, 32'hFF);
    rd(`PM_OFF_OSC, 32'h08);
    rd(8'h30, 32'h0);
    chk(serr, 1);
    // watchdog clears and run-mode time-out
    cpu.pulse(CLR);
    @(negedge pclk);
    chk(wdt_clear, 1);
    wr(`PM_OFF_CFG, 32'h20);
    cpu.pulse(LOST);
    @(negedge pclk);
    chk(wdt_clear, 1);
    cpu.pulse(WDT);
    @(negedge pclk);
    chk({wdt_reset, cpu_clk_en}, 2'h3);
    // primary idle on external clock: no start-up timer
    wr(`PM_OFF_CFG, 32'h11);
    wr(`PM_OFF_OSC, 32'h80);
    cpu.pulse(SLP);
    rd(`PM_OFF_STAT, 32'h3);
    wake(IRQ, TC + 2, 1'b0);
    // late sleep after deep enable expired: plain sleep, watchdog wake
    wr(`PM_OFF_CFG, 32'h10);
    wr(`PM_OFF_WDT, 32'h80);
    wr(`PM_OFF_OSC, 32'h00);
    wr(`PM_OFF_DSH, 32'h80);
    repeat (8) @(posedge pclk);
    rd(`PM_OFF_DSH, 32'h0);
    cpu.pulse(SLP);
    rd(`PM_OFF_STAT, 32'h4);
    chk(core_reg_en, 1);
    wake(WDT, TC + OC + 1, 1'b0);
    // secondary idle refused without oscillator enable
    wr(`PM_OFF_OSC, 32'h81);
    cpu.pulse(SLP);
    @(negedge pclk);
    chk(cpu_clk_en, 1);
    rd(`PM_OFF_STAT, 32'h0);
    // secondary idle, vectored wake
    wr(`PM_OFF_IRQ, 32'h80);
    wr(`PM_OFF_OSC, 32'h85);
    cpu.pulse(SLP);
    @(negedge pclk);
    chk({cpu_clk_en, periph_clk_en, pri_osc_en, sys_clk_sel}, 5'h09);
    rd(`PM_OFF_OSC, 32'hC5);
    wake(IRQ, TC + 2, 1'b1);
    chk(sys_clk_sel, 1);
    rd(`PM_OFF_OSC, 32'hC5);
    // internal idle, unvectored wake onto low-frequency oscillator
    wr(`PM_OFF_IRQ, 32'h0);
    wr(`PM_OFF_OSC, 32'h86);
    cpu.pulse(SLP);
    @(negedge pclk);
    chk({cpu_clk_en, periph_clk_en, pri_osc_en, sys_clk_sel}, 5'h0A);
    wake(IRQ, TC + 2, 1'b0);
    chk({sys_clk_sel, lf_osc_en}, 3'h7);
    // deep sleep with alarm wake, then ext_irq_zero too late to be logged
    wr(`PM_OFF_OSC, 32'h02);
    wr(`PM_OFF_WDT, 32'h80);
    wr(`PM_OFF_GPR0, 32'h5A);
    wr(`PM_OFF_GPR1, 32'hC3);
    wr(`PM_OFF_DIR, 32'hF0);
    wr(`PM_OFF_LAT, 32'hA5);
    deep();
    chk({pin_oe, pin_out & 8'h0F}, 16'h0F05);
    cpu.on(ALM);
    cpu.on(EXT_IRQ_ZERO);
    cpu.off(ALM | EXT_IRQ_ZERO);
    repeat (4) @(negedge pclk);
    chk(por_seen, 1);
    rd(`PM_OFF_WDT, 32'h08);
    rd(`PM_OFF_WAKE, 32'h02);
    rd(`PM_OFF_GPR0, 32'h5A);
    rd(`PM_OFF_GPR1, 32'hC3);
    rd(`PM_OFF_DIR, 32'hFF);
    wr(`PM_OFF_DIR, 32'h00);
    repeat (2) @(negedge pclk);
    chk(pin_oe, 8'h0F);
    wr(`PM_OFF_DSL, 32'h0);
    repeat (2) @(negedge pclk);
    chk({pin_oe, pin_out}, 16'hFF00);
    wr(`PM_OFF_WDT, 32'h0);
    rd(`PM_OFF_WDT, 32'h0);
    // deep sleep left by master clear: pins free, scratch kept
    wr(`PM_OFF_WDT, 32'h80);
    deep();
    cpu.pulse(MCL);
    repeat (4) @(negedge pclk);
    chk(pin_oe, 8'h00);
    rd(`PM_OFF_GPR0, 32'h5A);
    rd(`PM_OFF_WAKE, 32'h01);
    // a source already up aborts deep entry: no power-down, nothing logged
    wr(`PM_OFF_WDT, 32'h80);
    cpu.on(ALM);
    wr(`PM_OFF_DSH, 32'h80);
    cpu.pulse(SLP);
    repeat (3) @(negedge pclk);
    chk(core_reg_en, 1);
    rd(`PM_OFF_WAKE, 32'h0);
    cpu.off(ALM);
    chk(por_seen, 2);
    // reset out of plain sleep lands on the low-frequency oscillator
    wr(`PM_OFF_WDT, 32'h0);
    cpu.pulse(SLP);
    cpu.pulse(MCL);
    repeat (TC + OC + 8) @(negedge pclk);
    chk({cpu_clk_en, sys_clk_sel}, 3'h7);
    end_sim();
  end
endmodule
